// ### sebs_cfg.svh
// Purpose: constants of the serial EEPROM bus slave
// Assumes: system clock of 4 ns
// Notes:   definitions only
`ifndef SEBS_CFG_SVH
`define SEBS_CFG_SVH

`define SEBS_CLK_PERIOD_NS 4
`define SEBS_TWC_NS        5000000
`define SEBS_ADDR_W        13
`define SEBS_MEM_WORDS     8192
`define SEBS_PAGE_BYTES    32
`define SEBS_WC_W          21
`define SEBS_BIT_ACK       4'h8
`define SEBS_BIT_DONE      4'h9
`define SEBS_RST_PTR       13'h0000
`define SEBS_ADDR_HI_MSB   4
`define SEBS_PAGE_LSB      5

`endif

// ### sebs_pkg.sv
// Purpose: types of the serial EEPROM bus slave
// Assumes: nothing
// Notes:   constants live in sebs_cfg.svh
`default_nettype none
package sebs_pkg;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_CTRL    = 3'b001,
        ST_ADDR_HI = 3'b010,
        ST_ADDR_LO = 3'b011,
        ST_WDATA   = 3'b100,
        ST_RDATA   = 3'b101
    } sebs_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } sebs_line_t;

endpackage
`default_nettype wire

// ### sebs_core.sv
// Purpose: two-wire bus slave and storage of a 64 Kbit serial EEPROM
// Assumes: master drives SCL; SDA is open drain, resolved outside
// Notes:   SCL clocks bit capture; all decisions run on clock_i
`timescale 1ns/1ps
`include "sebs_cfg.svh"
`default_nettype none

module sebs_core
    import sebs_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE     = 4'h5,                                   // Arbitrary device-type code
    parameter int         WRITE_CYCLES = `SEBS_TWC_NS / `SEBS_CLK_PERIOD_NS      // Write cycle length in clocks
) (
    input  wire logic clock_i,            // System clock, 250 MHz
    input  wire logic nrst_i,             // Async reset, active low
    input  wire logic scl_clk_i,          // Bus clock from the master
    input  wire logic sda_i,              // Bus data line level
    input  wire logic chip_select_bit0_i, // Chip select strap, bit 0
    input  wire logic chip_select_bit1_i, // Chip select strap, bit 1
    input  wire logic chip_select_bit2_i, // Chip select strap, bit 2
    input  wire logic wp_i,               // Write protect, active high
    output var  logic sda_o,              // Data line drive value, always low
    output var  logic sda_oe_o,           // Data line pull-down enable
    output var  logic wr_busy_o           // Internal write cycle running
);

    // All checks sit in the system clock domain
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    // Link domain: one sample and one toggle per SCL pulse
    logic link_bit;
    logic link_tog;

    always_ff @(posedge scl_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            link_bit <= 1'b1;
            link_tog <= 1'b0;
        end else begin
            link_bit <= sda_i;
            link_tog <= ~link_tog;
        end
    end

    // System domain synchronisers
    sebs_line_t line_m;
    sebs_line_t line_s;
    sebs_line_t line_p;
    logic       tog_m;
    logic       tog_s;
    logic       tog_p;
    logic [2:0] cs_m;
    logic [2:0] cs_s;
    logic       wp_m;
    logic       wp_s;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            line_m <= '{scl: 1'b1, sda: 1'b1};
            line_s <= '{scl: 1'b1, sda: 1'b1};
            line_p <= '{scl: 1'b1, sda: 1'b1};
            tog_m  <= 1'b0;
            tog_s  <= 1'b0;
            tog_p  <= 1'b0;
        end else begin
            line_m <= '{scl: scl_clk_i, sda: sda_i};
            line_s <= line_m;
            line_p <= line_s;
            tog_m  <= link_tog;
            tog_s  <= tog_m;
            tog_p  <= tog_s;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cs_m <= 3'h0;
            cs_s <= 3'h0;
            wp_m <= 1'b0;
            wp_s <= 1'b0;
        end else begin
            cs_m <= {chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i};
            cs_s <= cs_m;
            wp_m <= wp_i;
            wp_s <= wp_m;
        end
    end

    // Edge of SDA with SCL high on both samples is a condition, not data
    logic start_det;
    logic stop_det;
    logic scl_fall;
    logic bit_evt;

    assign start_det = line_s.scl & line_p.scl & line_p.sda & ~line_s.sda;
    assign stop_det  = line_s.scl & line_p.scl & ~line_p.sda & line_s.sda;
    assign scl_fall  = line_p.scl & ~line_s.scl;
    // Bit value stays stable for a full SCL period after its toggle
    assign bit_evt   = tog_s ^ tog_p;

    // Storage and bus state
    logic [7:0]              mem [`SEBS_MEM_WORDS];
    logic [7:0]              page_buf [`SEBS_PAGE_BYTES];
    logic [31:0]             page_mask;
    sebs_state_t             state;
    logic [3:0]              bitcnt;
    logic [7:0]              shift;
    logic [`SEBS_ADDR_W-1:0] ptr;
    logic                    mack;
    logic [`SEBS_WC_W-1:0]   wc_cnt;
    logic [7:0]              commit_page;
    logic                    ctrl_match;
    logic                    commit_go;
    logic                    wr_stb;
    logic [7:0]              rd_byte;

    assign ctrl_match = (shift[7:4] == DEV_TYPE) && (shift[3:1] == cs_s) && !wr_busy_o;
    assign wr_stb     = scl_fall && (state == ST_WDATA) && (bitcnt == `SEBS_BIT_DONE);
    assign commit_go  = stop_det && (state == ST_WDATA) && (|page_mask) && !wp_s;
    assign rd_byte    = mem[ptr];

    // Bus protocol
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state    <= ST_IDLE;
            bitcnt   <= 4'h0;
            shift    <= 8'h00;
            ptr      <= `SEBS_RST_PTR;
            mack     <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (start_det) begin
            state    <= ST_CTRL;
            bitcnt   <= 4'h0;
            sda_oe_o <= 1'b0;
        end else if (stop_det) begin
            state    <= ST_IDLE;
            bitcnt   <= 4'h0;
            sda_oe_o <= 1'b0;
        end else if (state != ST_IDLE) begin
            if (bit_evt) begin
                bitcnt <= bitcnt + 4'h1;
                if (state != ST_RDATA && bitcnt < `SEBS_BIT_ACK) begin
                    shift <= {shift[6:0], link_bit};
                end
                if (state == ST_RDATA && bitcnt == `SEBS_BIT_ACK) begin
                    mack <= ~link_bit;
                end
            end else if (scl_fall) begin
                // Drive changes here while SCL is low; otherwise only Start and Stop clear it
                if (state == ST_RDATA) begin
                    if (bitcnt < `SEBS_BIT_ACK) begin
                        shift    <= {shift[6:0], 1'b1};
                        sda_oe_o <= ~shift[6];
                    end else if (bitcnt == `SEBS_BIT_ACK) begin
                        sda_oe_o <= 1'b0;
                    end else if (mack) begin
                        shift    <= rd_byte;
                        sda_oe_o <= ~rd_byte[7];
                        ptr      <= ptr + 13'h0001;
                        bitcnt   <= 4'h0;
                    end else begin
                        state    <= ST_IDLE;
                        sda_oe_o <= 1'b0;
                        bitcnt   <= 4'h0;
                    end
                end else if (bitcnt == `SEBS_BIT_ACK) begin
                    sda_oe_o <= (state == ST_CTRL) ? ctrl_match : 1'b1;
                end else if (bitcnt == `SEBS_BIT_DONE) begin
                    sda_oe_o <= 1'b0;
                    bitcnt   <= 4'h0;
                    case (state)
                        ST_CTRL: begin
                            if (!sda_oe_o) begin
                                state <= ST_IDLE;
                            end else if (shift[0]) begin
                                state    <= ST_RDATA;
                                shift    <= rd_byte;
                                sda_oe_o <= ~rd_byte[7];
                                ptr      <= ptr + 13'h0001;
                            end else begin
                                state <= ST_ADDR_HI;
                            end
                        end
                        ST_ADDR_HI: begin
                            ptr[`SEBS_ADDR_W-1:8] <= shift[`SEBS_ADDR_HI_MSB:0];
                            state <= ST_ADDR_LO;
                        end
                        ST_ADDR_LO: begin
                            ptr[7:0] <= shift;
                            state    <= ST_WDATA;
                        end
                        ST_WDATA: begin
                            ptr[`SEBS_PAGE_LSB-1:0] <= ptr[`SEBS_PAGE_LSB-1:0] + 5'h01;
                        end
                        default: begin
                            state <= ST_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // Line is only ever pulled low
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    // Page buffer indexed by pointer low bits, so byte 33 lands on byte 1
    always_ff @(posedge clock_i) begin
        if (wr_stb) begin
            page_buf[ptr[`SEBS_PAGE_LSB-1:0]] <= shift;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            page_mask <= 32'h00000000;
        end else if (start_det && !wr_busy_o) begin
            page_mask <= 32'h00000000;
        end else if (wr_stb) begin
            page_mask[ptr[`SEBS_PAGE_LSB-1:0]] <= 1'b1;
        end
    end

    // Self-timed write cycle; first 32 clocks copy the page into the array
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_busy_o   <= 1'b0;
            wc_cnt      <= '0;
            commit_page <= 8'h00;
        end else if (commit_go) begin
            wr_busy_o   <= 1'b1;
            wc_cnt      <= '0;
            commit_page <= ptr[`SEBS_ADDR_W-1:`SEBS_PAGE_LSB];
        end else if (wr_busy_o) begin
            wc_cnt <= wc_cnt + 21'h000001;
            if (wc_cnt == `SEBS_WC_W'(WRITE_CYCLES - 1)) begin
                wr_busy_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (wr_busy_o && (wc_cnt[`SEBS_WC_W-1:5] == 16'h0000) && page_mask[wc_cnt[4:0]]) begin
            mem[{commit_page, wc_cnt[4:0]}] <= page_buf[wc_cnt[4:0]];
        end
    end

    // Checks

    property p_start;
        start_det |=> state == ST_CTRL && bitcnt == 4'h0 && !sda_oe_o;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_stop;
        stop_det && !start_det |=> state == ST_IDLE && !sda_oe_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not taken");

    property p_cond_not_data;
        (start_det || stop_det) |=> bitcnt == 4'h0 && $stable(shift);
    endproperty
    a_cond_not_data: assert property (p_cond_not_data) else $error("condition counted as data");

    property p_ack_rx;
        scl_fall && !start_det && !stop_det && bitcnt == `SEBS_BIT_ACK
            && (state == ST_ADDR_HI || state == ST_ADDR_LO || state == ST_WDATA) |=> sda_oe_o;
    endproperty
    a_ack_rx: assert property (p_ack_rx) else $error("no acknowledge on received byte");

    property p_ack_hold;
        (state == ST_ADDR_HI || state == ST_ADDR_LO || state == ST_WDATA)
            && bitcnt == `SEBS_BIT_DONE |-> sda_oe_o;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("acknowledge dropped in ninth pulse");

    property p_busy_nack;
        wr_busy_o && state == ST_CTRL |-> ##1 (sda_oe_o == 1'b0) || $past(bitcnt) != `SEBS_BIT_ACK
            || !$past(scl_fall);
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("acknowledge during write cycle");

    property p_release_nack;
        state == ST_RDATA && scl_fall && bitcnt == `SEBS_BIT_DONE && !mack && !start_det && !stop_det
            |=> state == ST_IDLE && !sda_oe_o;
    endproperty
    a_release_nack: assert property (p_release_nack) else $error("line held after not-acknowledge");

    property p_drive_low_only;
        $changed(sda_oe_o) |-> !line_p.scl || $past(start_det) || $past(stop_det);
    endproperty
    a_drive_low_only: assert property (p_drive_low_only) else $error("drive changed with clock high");

    property p_wc_bound;
        wr_busy_o |-> wc_cnt < `SEBS_WC_W'(WRITE_CYCLES);
    endproperty
    a_wc_bound: assert property (p_wc_bound) else $error("write cycle overran");

    property p_wp_block;
        stop_det && state == ST_WDATA && wp_s && !wr_busy_o |=> !wr_busy_o;
    endproperty
    a_wp_block: assert property (p_wp_block) else $error("protected write started");

    property p_page_wrap;
        state == ST_WDATA && !start_det |=> $stable(ptr[`SEBS_ADDR_W-1:`SEBS_PAGE_LSB]);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page pointer left its page");

    property p_sda_low;
        sda_o == 1'b0;
    endproperty
    a_sda_low: assert property (p_sda_low) else $error("data line driven high");

endmodule // sebs_core
`default_nettype wire

// ### sebs_master_model.sv
// Purpose: two-wire bus master that drives the EEPROM slave
// Assumes: data line has a pull-up, resolved by the bench
// Notes:   SCL stands high between frames; all moves on link clock edges
`timescale 1ns/1ps
`default_nettype none

module sebs_master_model (
    input  wire logic link_clk_i, // Link clock, 32 ns
    input  wire logic sda_i,      // Resolved data line
    output var  logic scl_o,      // Serial clock, master only
    output var  logic sda_pull_o  // High pulls data line low
);
    initial begin
        scl_o      = 1'b1;
        sda_pull_o = 1'b0;
    end

    // Also serves as repeated Start: line released while SCL low
    task automatic bus_start();
        @(posedge link_clk_i) sda_pull_o <= 1'b0;
        @(posedge link_clk_i) scl_o <= 1'b1;
        @(posedge link_clk_i) sda_pull_o <= 1'b1;
        @(posedge link_clk_i) scl_o <= 1'b0;
    endtask

    task automatic bus_stop();
        @(posedge link_clk_i) sda_pull_o <= 1'b1;
        @(posedge link_clk_i) scl_o <= 1'b1;
        @(posedge link_clk_i) sda_pull_o <= 1'b0;
    endtask

    task automatic bus_bit(input logic b, output logic r);
        @(posedge link_clk_i) sda_pull_o <= ~b;
        @(posedge link_clk_i) scl_o <= 1'b1;
        @(posedge link_clk_i) begin
            r = sda_i;
            scl_o <= 1'b0;
        end
    endtask

    task automatic byte_w(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bus_bit(d[i], r);
        bus_bit(1'b1, r);
        ack = ~r;
    endtask

    task automatic byte_r(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bus_bit(1'b1, r);
            d[i] = r;
        end
        bus_bit(last, r);
    endtask
endmodule // sebs_master_model

`default_nettype wire

// ### sebs_core_tb.sv
// Purpose: self-checking bench of the serial EEPROM bus slave
// Assumes: master model on a 32 ns link clock, pull-up on data line
// Notes:   short write cycle so ack polling and wait stay cheap
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected at %0t ns: got %h expected %h", $time, (g), (e)); end end

module sebs_core_tb;
    import sebs_pkg::*;
    localparam int         WC   = 4096;
    localparam logic [3:0] TYPE = 4'h5; // Arbitrary type code
    logic       clock_i  = 1'b0;
    logic       link_clk = 1'b0;
    logic       nrst_i   = 1'b1;
    logic       wp       = 1'b0;
    logic [2:0] cs       = 3'h0;
    logic       scl, m_pull, sda_o, sda_oe, wr_busy;
    wire  logic sda_line;
    int         n_errors = 0;
    int         check_count = 0;
    int         cycles = 0;
    logic [7:0] exp_mem [0:8191];

    assign sda_line = ~(m_pull | sda_oe); // Open drain, pulled up

    always #2 clock_i = ~clock_i;
    initial begin
        #7;
        forever #16 link_clk = ~link_clk;
    end

    sebs_core #(.DEV_TYPE(TYPE), .WRITE_CYCLES(WC)) dut (
        .clock_i(clock_i), .nrst_i(nrst_i), .scl_clk_i(scl), .sda_i(sda_line),
        .chip_select_bit0_i(cs[0]), .chip_select_bit1_i(cs[1]), .chip_select_bit2_i(cs[2]),
        .wp_i(wp), .sda_o(sda_o), .sda_oe_o(sda_oe), .wr_busy_o(wr_busy));
    sebs_master_model master (.link_clk_i(link_clk), .sda_i(sda_line), .scl_o(scl), .sda_pull_o(m_pull));

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            n_errors++;
            close_out();
        end
    end

    function automatic logic [7:0] ctrl(input logic [2:0] sel, input logic rd);
        return {TYPE, sel, rd};
    endfunction

    function automatic logic [12:0] page_addr(input logic [12:0] a, input int k);
        return {a[12:5], 5'(a[4:0] + k)};
    endfunction

    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic ack;
        master.byte_w(d, ack);
        `CHK(ack, exp_ack)
        `CHK(sda_o, 1'b0)
    endtask

    task automatic set_addr(input logic [12:0] a);
        master.bus_start();
        send(ctrl(cs, 1'b0), 1'b1);
        send({3'($urandom), a[12:8]}, 1'b1);
        send(a[7:0], 1'b1);
    endtask

    task automatic page_write(input logic [12:0] a, input int n, input logic prot);
        logic [7:0] d;
        realtime    t0;
        set_addr(a);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            send(d, 1'b1);
            if (!prot) exp_mem[page_addr(a, k)] = d;
        end
        master.bus_stop();
        t0 = $realtime;
        repeat (10) @(posedge clock_i);
        `CHK(wr_busy, ~prot)
        // Ack polling while the cycle runs
        master.bus_start();
        send(ctrl(cs, 1'b0), prot);
        master.bus_stop();
        for (int i = 0; i < WC + 100 && wr_busy !== 1'b0; i++) @(posedge clock_i);
        `CHK(wr_busy, 1'b0)
        if (!prot) `CHK(($realtime - t0) <= 4.0 * (WC + 8) && ($realtime - t0) >= 4.0 * WC, 1'b1)
    endtask

    task automatic read_check(input logic [12:0] a, input int n);
        logic [7:0] d;
        set_addr(a);
        master.bus_start();
        send(ctrl(cs, 1'b1), 1'b1);
        for (int k = 0; k < n; k++) begin
            master.byte_r(k == n - 1, d);
            `CHK(d, exp_mem[13'(a + k)])
        end
        repeat (6) @(posedge clock_i);
        `CHK(sda_oe, 1'b0)
        master.bus_stop();
    endtask

    initial begin
        logic [12:0] a;
        int          n;
        void'($urandom(21248));
        nrst_i <= 1'b0; // Real falling edge, so the async reset branches run at time zero
        repeat (12) @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (8) @(posedge clock_i);
        `CHK(sda_oe, 1'b0)
        `CHK(wr_busy, 1'b0)
        // Refusals; bytes after a refusal need a fresh Start
        master.bus_start();
        send(ctrl(~cs, 1'b0), 1'b0);
        master.bus_start();
        send({~TYPE, cs, 1'b0}, 1'b0);
        send(ctrl(cs, 1'b0), 1'b0);
        master.bus_stop();
        $display("test refusals done");
        for (int it = 0; it < 3; it++) begin
            @(posedge clock_i) cs <= 3'($urandom);
            repeat (8) @(posedge clock_i);
            n = (it == 0) ? 34 : (it == 1) ? 1 : 2 + int'($urandom_range(29));
            a = 13'($urandom);
            if (n < 32) a[4:0] = 5'($urandom_range(32 - n));
            page_write(a, n, 1'b0);
            if (n >= 32) a[4:0] = 5'h00;
            read_check(a, (n >= 32) ? 32 : n);
            $display("test page write of %0d bytes done", n);
        end
        // Protected write leaves data alone
        @(posedge clock_i) wp <= 1'b1;
        repeat (8) @(posedge clock_i);
        page_write(a, 2, 1'b1);
        @(posedge clock_i) wp <= 1'b0;
        // Write cut short by repeated Start is dropped
        set_addr(a);
        send(8'hA5, 1'b1);
        master.bus_start();
        master.bus_stop();
        repeat (10) @(posedge clock_i);
        `CHK(wr_busy, 1'b0)
        // Stale byte of the cut write must not ride along with the next one
        page_write(page_addr(a, 1), 1, 1'b0);
        read_check(a, 2);
        $display("test protect and abort done");
        close_out();
    end
endmodule // sebs_core_tb

`default_nettype wire
